// >>> icpd_bank_model.sv
/*
  Behavioural page bank standing behind the register page decoder.
  Assumes the decoder's bank port on clk_sys_i and a delay chosen by the bench.
*/
`timescale 1ns/1ps
module icpd_bank_model import icpd_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [1:0] delay_i,
  input wire logic bank_valid_i,
  input wire icpd_kind_type bank_kind_i,
  input wire logic [7:0] bank_unit_i,
  input wire logic [15:0] bank_offset_i,
  output logic bank_done_o,
  output logic [63:0] bank_rdata_o
);
  logic [1:0] wait_q;
  logic [63:0] word;
  // Stall up to delay_i cycles so prompt and slow banks are both seen
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !bank_valid_i || bank_done_o) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  assign bank_done_o = bank_valid_i && (wait_q == delay_i);
  assign word = {bank_offset_i, bank_unit_i, 4'h0, bank_kind_i, 16'hc3c3, bank_offset_i};
  // Outside the done cycle the data lines carry the inverse, never the answer
  assign bank_rdata_o = bank_done_o ? word : ~word;
endmodule

// >>> icpd_map.svh
/*
  Address map constants for the register page decoder.
  Assumes a 64 KB page size and 16-bit in-page offsets.
*/
`ifndef ICPD_MAP_SVH
`define ICPD_MAP_SVH
`define ICPD_PAGE_LSB 16
`define ICPD_PG_DIST 16'h0000
`define ICPD_PG_MSG 16'h0001
`define ICPD_PG_TRACE 16'h0002
`define ICPD_PG_PERF 16'h0003
`define ICPD_PG_ITS0 16'h0004
`define ICPD_OFS_ID_BASE 16'hffd0
`define ICPD_OFS_PART_LO 16'hffe0
`define ICPD_OFS_PART_HI 16'hffe4
`define ICPD_RST_WORD 32'h0000_0000
`define ICPD_RST_TIE 16'h0000
`endif

// >>> icpd_pkg.sv
/*
  Types shared by the register page decoder.
  Assumes nothing beyond a SystemVerilog tool.
*/
package icpd_pkg;
  typedef enum logic [3:0] {
    KIND_DIST, KIND_MSG, KIND_TRACE, KIND_PERF,
    KIND_ITS_CTRL, KIND_ITS_XLATE, KIND_ITS_VSGI,
    KIND_RD_LPI, KIND_RD_SGI, KIND_RD_VLPI,
    KIND_ALIAS, KIND_RESERVED
  } icpd_kind_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BANK = 3'b010,
    ST_RESP = 3'b100
  } icpd_state_type;
  typedef struct packed {
    icpd_kind_type kind;
    logic [7:0] unit;
  } icpd_page_type;
endpackage

// >>> icpd_register_page_decoder.sv
/*
  Register page decoder: takes one register access at a time from the
  subordinate port, decodes the page, answers reserved, blocked and
  identification accesses itself and forwards the rest to page banks.
  Assumes the bus side and the banks run on clk_sys_i; tie-off pins are
  asynchronous and resynchronised here.
*/
// What this block does
// - Memory-mapped registers only, fixed offsets from base
// - Reserved access errors per enable and disable
// - Reset clears all register bits to zero except state_q, which loads ST_IDLE (3'b001)
// - Data path 64, 128, 256 or 512 bits
// - Doubleword access is single-copy atomic
// - Little-endian data only
// - Write-only unknown read, read-only ignores writes
// - Security disable opens secure pages to non-secure
// - Pages 0 to 3: dist, message, trace, perf
// - Translator pages at 4 plus stride times index
// - Redistributor pages follow translators, four kinds
// - Alias page sits above last active redistributor
// - Page chosen from address bits x down to 16
// - Non-monolithic ignores bits above fold limit
// - Monolithic tie-offs give dist and translate pages
// - Identification part number at 0xFFE0 and 0xFFE4
// - Four pages per redistributor, type register reports
// - Processor numbers used for translator targets
// - Reserved offsets read zero, writes ignored
// - Non-secure to secure-only reads zero, ignores writes
`timescale 1ns/1ps
`include "icpd_map.svh"
module icpd_register_page_decoder import icpd_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64,
  parameter int ITS_TOTAL = 2,
  parameter int REDIST_MAX = 8,
  parameter bit V41 = 1'b1,
  parameter bit MONOLITHIC = 1'b0,
  // Part numbers: arbitrary values
  parameter logic [11:0] PART_DIST = 12'h0a1,
  parameter logic [11:0] PART_REDIST = 12'h0a2,
  parameter logic [11:0] PART_ITS = 12'h0a3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [DATA_W/8-1:0] req_strb_i,
  input wire logic req_nonsecure_i,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic rsp_error_o,
  input wire logic err_ctrl_uncorrectable_enable_i,
  input wire logic bus_error_disable_i,
  input wire logic security_disable_i,
  input wire logic [$clog2(REDIST_MAX+1)-1:0] redist_total_i,
  input wire logic [15:0] dist_page_tieoff_i,
  input wire logic [15:0] xlate_page_tieoff_i,
  output logic bank_valid_o,
  output icpd_kind_type bank_kind_o,
  output logic [7:0] bank_unit_o,
  output logic [15:0] bank_offset_o,
  output logic bank_write_o,
  output logic [DATA_W-1:0] bank_wdata_o,
  output logic [DATA_W/8-1:0] bank_strb_o,
  input wire logic bank_done_i,
  input wire logic [DATA_W-1:0] bank_rdata_i,
  output logic bad_access_o
);
  localparam int PG_W = ADDR_W - `ICPD_PAGE_LSB;
  localparam int RW = $clog2(REDIST_MAX + 1);
  localparam int SH = V41 ? 2 : 1;
  localparam int PAGE_TOTAL = 4 + ((ITS_TOTAL + REDIST_MAX) << SH) + 1;
  localparam int FOLD_W = $clog2(PAGE_TOTAL);
  localparam int BL = $clog2(DATA_W / 8);
  localparam int NW = DATA_W / 32;
  localparam logic [PG_W-1:0] FOLD_MASK = PG_W'((64'd1 << FOLD_W) - 64'd1);
  localparam logic [PG_W-1:0] ITS_BASE = PG_W'(`ICPD_PG_ITS0);
  localparam logic [PG_W-1:0] RD_BASE = PG_W'(4 + (ITS_TOTAL << SH));
  localparam logic [1:0] SUB_MASK = V41 ? 2'd3 : 2'd1;

  // Data path limited to the four legal widths
  if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256 && DATA_W != 512) begin : g_bad_width
    $error("Data width must be 64, 128, 256 or 512");
  end

  function automatic icpd_page_type decode_page(input logic [PG_W-1:0] pg, input logic [RW-1:0] rtot);
    icpd_page_type p;
    logic [PG_W-1:0] rel;
    logic [PG_W-1:0] rd_end;
    logic [1:0] sub;
    p.kind = KIND_RESERVED;
    p.unit = 8'h00;
    rel = '0;
    sub = 2'd0;
    rd_end = RD_BASE + (PG_W'(rtot) << SH);
    if (pg == PG_W'(`ICPD_PG_DIST)) begin
      p.kind = KIND_DIST;
    end else if (pg == PG_W'(`ICPD_PG_MSG)) begin
      p.kind = KIND_MSG;
    end else if (pg == PG_W'(`ICPD_PG_TRACE)) begin
      p.kind = KIND_TRACE;
    end else if (pg == PG_W'(`ICPD_PG_PERF)) begin
      p.kind = KIND_PERF;
    end else if (pg < RD_BASE) begin
      rel = pg - ITS_BASE;
      sub = rel[1:0] & SUB_MASK;
      p.unit = 8'(rel >> SH);
      unique case (sub)
        2'd0: p.kind = KIND_ITS_CTRL;
        2'd1: p.kind = KIND_ITS_XLATE;
        2'd2: p.kind = KIND_ITS_VSGI;
        2'd3: p.kind = KIND_RESERVED;
      endcase
    end else if (pg < rd_end) begin
      rel = pg - RD_BASE;
      sub = rel[1:0] & SUB_MASK;
      p.unit = 8'(rel >> SH);
      unique case (sub)
        2'd0: p.kind = KIND_RD_LPI;
        2'd1: p.kind = KIND_RD_SGI;
        2'd2: p.kind = KIND_RD_VLPI;
        2'd3: p.kind = KIND_RESERVED;
      endcase
    end else if (pg == rd_end) begin
      p.kind = KIND_ALIAS;
    end
    return p;
  endfunction
  function automatic logic [11:0] part_of(input icpd_kind_type k);
    logic [11:0] v;
    v = 12'h000;
    if (k == KIND_DIST || k == KIND_ALIAS) begin
      v = PART_DIST;
    end else if (k == KIND_RD_LPI || k == KIND_RD_SGI || k == KIND_RD_VLPI) begin
      v = PART_REDIST;
    end else if (k == KIND_ITS_CTRL || k == KIND_ITS_XLATE || k == KIND_ITS_VSGI) begin
      v = PART_ITS;
    end
    return v;
  endfunction
  // Tie-off pins are asynchronous to the bus clock
  logic [15:0] dist_tie_s1_q, dist_tie_q, xlate_tie_s1_q, xlate_tie_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {dist_tie_s1_q, dist_tie_q, xlate_tie_s1_q, xlate_tie_q} <= {4{`ICPD_RST_TIE}};
    end else begin
      {dist_tie_s1_q, xlate_tie_s1_q} <= {dist_page_tieoff_i, xlate_page_tieoff_i};
      {dist_tie_q, xlate_tie_q} <= {dist_tie_s1_q, xlate_tie_s1_q};
    end
  end
  logic [PG_W-1:0] pg_raw, pg_sel;
  icpd_page_type pg_dec;
  logic [11:0] part;
  logic [DATA_W-1:0] id_data;
  logic [15:0] word_ofs;
  logic id_hit, secure_block;
  always_comb begin
    pg_raw = req_addr_i[ADDR_W-1:`ICPD_PAGE_LSB];
    pg_sel = pg_raw & FOLD_MASK;
    if (MONOLITHIC) begin
      // Other pages sit relative to the distributor tie-off
      pg_sel = pg_raw - PG_W'(dist_tie_q);
    end
    pg_dec = decode_page(pg_sel, redist_total_i);
    // Distributor tie-off wins if both tie-offs name one page
    if (MONOLITHIC && (pg_raw == PG_W'(dist_tie_q) || pg_raw == PG_W'(xlate_tie_q))) begin
      pg_dec.kind = (pg_raw == PG_W'(dist_tie_q)) ? KIND_DIST : KIND_ITS_XLATE;
      pg_dec.unit = 8'h00;
    end
    part = part_of(pg_dec.kind);
    id_hit = req_addr_i[15:0] >= `ICPD_OFS_ID_BASE;
    // Trace and perf pages are secure-only unless security is disabled
    secure_block = req_nonsecure_i && !security_disable_i &&
                   (pg_dec.kind == KIND_TRACE || pg_dec.kind == KIND_PERF);
    id_data = '0;
    word_ofs = 16'h0000;
    for (int w = 0; w < NW; w++) begin
      word_ofs = {req_addr_i[15:BL], BL'(w * 4)};
      if (word_ofs == `ICPD_OFS_PART_LO) begin
        id_data[w*32 +: 32] = {24'h00_0000, part[7:0]};
      end else if (word_ofs == `ICPD_OFS_PART_HI) begin
        id_data[w*32 +: 32] = {28'h000_0000, part[11:8]};
      end
    end
  end
  icpd_state_type state_q, state_d;
  icpd_kind_type kind_q, kind_d;
  logic [7:0] unit_q, unit_d;
  logic [15:0] ofs_q, ofs_d;
  logic write_q, write_d, err_q, err_d, bad_q, bad_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [DATA_W/8-1:0] strb_q, strb_d;
  logic take;
  assign take = req_valid_i && state_q == ST_IDLE;
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    unit_d = unit_q;
    ofs_d = ofs_q;
    write_d = write_q;
    wdata_d = wdata_q;
    strb_d = strb_q;
    rdata_d = rdata_q;
    err_d = err_q;
    bad_d = bad_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          // Whole beat captured at once so no torn doubleword
          kind_d = pg_dec.kind;
          unit_d = pg_dec.unit;
          ofs_d = req_addr_i[15:0];
          write_d = req_write_i;
          wdata_d = req_wdata_i;
          strb_d = req_strb_i;
          rdata_d = '0;
          err_d = 1'b0;
          bad_d = 1'b0;
          state_d = ST_BANK;
          if (pg_dec.kind == KIND_RESERVED) begin
            bad_d = 1'b1;
            err_d = err_ctrl_uncorrectable_enable_i && !bus_error_disable_i;
            state_d = ST_RESP;
          end else if (secure_block) begin
            state_d = ST_RESP;
          end else if (id_hit) begin
            rdata_d = req_write_i ? '0 : id_data;
            state_d = ST_RESP;
          end
        end
      end
      ST_BANK: begin
        if (bank_done_i) begin
          rdata_d = write_q ? '0 : bank_rdata_i;
          state_d = ST_RESP;
        end
      end
      ST_RESP: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      kind_q <= KIND_DIST;
      unit_q <= 8'h00;
      ofs_q <= 16'h0000;
      write_q <= 1'b0;
      wdata_q <= '0;
      strb_q <= '0;
      rdata_q <= '0;
      err_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      unit_q <= unit_d;
      ofs_q <= ofs_d;
      write_q <= write_d;
      wdata_q <= wdata_d;
      strb_q <= strb_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      bad_q <= bad_d;
    end
  end

  assign req_ready_o = state_q == ST_IDLE;
  assign rsp_valid_o = state_q == ST_RESP;
  assign rsp_rdata_o = rdata_q;
  assign rsp_error_o = err_q && state_q == ST_RESP;
  assign bad_access_o = bad_q && state_q == ST_RESP;
  assign bank_valid_o = state_q == ST_BANK;
  assign bank_kind_o = kind_q;
  assign bank_unit_o = unit_q;
  assign bank_offset_o = ofs_q;
  assign bank_write_o = write_q;
  assign bank_wdata_o = wdata_q;
  assign bank_strb_o = strb_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_reset_clear;
    $fell(rst_i) |-> !rsp_valid_o && !bank_valid_o && rsp_rdata_o == '0 && req_ready_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("State not cleared by reset");
  property p_rsvd_error;
    take && pg_dec.kind == KIND_RESERVED && err_ctrl_uncorrectable_enable_i && !bus_error_disable_i
      |=> rsp_valid_o && rsp_error_o && bad_access_o;
  endproperty
  a_rsvd_error: assert property (p_rsvd_error) else $error("Reserved access gave no error");
  property p_rsvd_raz;
    take && pg_dec.kind == KIND_RESERVED |=> rsp_valid_o && rsp_rdata_o == '0 && !bank_valid_o;
  endproperty
  a_rsvd_raz: assert property (p_rsvd_raz) else $error("Reserved access not read as zero");
  property p_secure_raz;
    take && req_nonsecure_i && !security_disable_i && pg_dec.kind == KIND_TRACE
      |=> rsp_valid_o && rsp_rdata_o == '0 && !rsp_error_o ##1 !bank_valid_o;
  endproperty
  a_secure_raz: assert property (p_secure_raz) else $error("Secure-only page reached");
  property p_secure_open;
    take && req_nonsecure_i && security_disable_i && pg_dec.kind == KIND_PERF && !id_hit
      |=> bank_valid_o && bank_kind_o == KIND_PERF;
  endproperty
  a_secure_open: assert property (p_secure_open) else $error("Security disable ignored");
  property p_page_trace;
    take && !MONOLITHIC && pg_raw == PG_W'(`ICPD_PG_TRACE) |=> bank_kind_o == KIND_TRACE;
  endproperty
  a_page_trace: assert property (p_page_trace) else $error("Page 2 not decoded as trace");
  property p_alias;
    take && !MONOLITHIC && pg_sel == RD_BASE + (PG_W'(redist_total_i) << SH) |=> bank_kind_o == KIND_ALIAS;
  endproperty
  a_alias: assert property (p_alias) else $error("Alias page misplaced");
  property p_offset;
    take |=> bank_offset_o == $past(req_addr_i[15:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("Page offset not carried");
  property p_atomic;
    bank_valid_o && !bank_done_i |=> $stable(bank_wdata_o) && $stable(bank_strb_o) && bank_valid_o;
  endproperty
  a_atomic: assert property (p_atomic) else $error("Write beat changed mid-access");
  property p_part_lo;
    take && !req_write_i && pg_dec.kind == KIND_DIST && req_addr_i[15:0] == `ICPD_OFS_PART_LO
      |=> rsp_valid_o && rsp_rdata_o[7:0] == PART_DIST[7:0];
  endproperty
  a_part_lo: assert property (p_part_lo) else $error("Wrong low part number");

  c_bank_read: cover property (take && !req_write_i ##1 bank_valid_o ##[1:8] rsp_valid_o);
  c_id_read: cover property (take && id_hit && pg_dec.kind == KIND_RD_LPI ##1 rsp_valid_o);
  c_error: cover property (rsp_valid_o && rsp_error_o);
  c_alias: cover property (take && pg_dec.kind == KIND_ALIAS);
endmodule

// >>> tb.sv
/*
  Self-checking bench for the register page decoder with a bank model.
  Assumes default parameters: 2 translators, up to 8 redistributors, v4.1 map.
*/
`timescale 1ns/1ps
module tb import icpd_pkg::*; ;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
  logic clk_sys_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, req_nonsecure_i = 0;
  logic ue = 0, dis = 0, sd = 0, req_ready_o, rsp_valid_o, rsp_error_o, bad_access_o;
  logic bank_valid_o, bank_write_o, bank_done_i, bank_seen = 0;
  logic [31:0] req_addr_i = 0;
  logic [63:0] req_wdata_i = 0, rsp_rdata_o, bank_wdata_o, bank_rdata_i;
  logic [7:0] req_strb_i = 0, bank_strb_o, bank_unit_o;
  logic [3:0] redist_total_i = 0;
  logic [1:0] delay = 0;
  logic [15:0] bank_offset_o;
  icpd_kind_type bank_kind_o;
  logic [65:0] rsp_q[$], re;
  logic [100:0] bank_q[$], be;
  int error_cnt = 0, checks_done = 0, seed = 32'h339a_2702;
  int pages[6] = '{0, 4, 5, 12, 14, 44};

  icpd_register_page_decoder icpd_register_page_decoder_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_strb_i(req_strb_i),
    .req_nonsecure_i(req_nonsecure_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .rsp_error_o(rsp_error_o), .err_ctrl_uncorrectable_enable_i(ue), .bus_error_disable_i(dis),
    .security_disable_i(sd), .redist_total_i(redist_total_i), .dist_page_tieoff_i(16'h0000),
    .xlate_page_tieoff_i(16'h0000), .bank_valid_o(bank_valid_o), .bank_kind_o(bank_kind_o),
    .bank_unit_o(bank_unit_o), .bank_offset_o(bank_offset_o), .bank_write_o(bank_write_o),
    .bank_wdata_o(bank_wdata_o), .bank_strb_o(bank_strb_o), .bank_done_i(bank_done_i),
    .bank_rdata_i(bank_rdata_i), .bad_access_o(bad_access_o));

  icpd_bank_model icpd_bank_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .delay_i(delay),
    .bank_valid_i(bank_valid_o), .bank_kind_i(bank_kind_o), .bank_unit_i(bank_unit_o),
    .bank_offset_i(bank_offset_o), .bank_done_o(bank_done_i), .bank_rdata_o(bank_rdata_i));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Expected page kind and unit for page p with n active redistributors
  function automatic void dec(input int p, input int n, output icpd_kind_type k, output int u);
    int q;
    q = p - 12;
    u = 0;
    if (p < 4) begin
      k = icpd_kind_type'(p);
    end else if (p < 12) begin
      u = (p - 4) / 4;
      k = (p % 4 == 3) ? KIND_RESERVED : icpd_kind_type'(4 + p % 4);
    end else if (q / 4 < n) begin
      u = q / 4;
      k = (q % 4 == 3) ? KIND_RESERVED : icpd_kind_type'(7 + q % 4);
    end else begin
      k = (q == 4 * n) ? KIND_ALIAS : KIND_RESERVED;
    end
  endfunction

  task automatic acc(input logic w, input logic [31:0] a, input logic ns, input int n);
    icpd_kind_type k;
    int u, i;
    logic [11:0] pn;
    logic [63:0] wd;
    logic [7:0] st;
    logic e_ue, e_dis, e_sd;
    dec(int'(a[21:16]), n, k, u);
    wd = {$random(seed), $random(seed)};
    st = 8'($random(seed));
    {e_ue, e_dis, e_sd} = 3'($random(seed));
    if (k == KIND_RESERVED) a[15] = 1'b0;
    case (k)
      KIND_DIST, KIND_ALIAS: pn = 12'h0a1;
      KIND_RD_LPI, KIND_RD_SGI, KIND_RD_VLPI: pn = 12'h0a2;
      KIND_ITS_CTRL, KIND_ITS_XLATE, KIND_ITS_VSGI: pn = 12'h0a3;
      default: pn = 12'h000;
    endcase
    if (k == KIND_RESERVED) begin
      rsp_q.push_back({64'h0, e_ue & ~e_dis, 1'b1});
    end else if (ns && !e_sd && (k == KIND_TRACE || k == KIND_PERF)) begin
      rsp_q.push_back(66'h0);
    end else if (a[15:0] >= 16'hffd0) begin
      rsp_q.push_back({(w || a[15:3] != 13'h1ffc) ? 64'h0 : {28'h0, pn[11:8], 24'h0, pn[7:0]}, 2'b00});
    end else begin
      bank_q.push_back({w, wd, st, k, u[7:0], a[15:0]});
      rsp_q.push_back({w ? 64'h0 : {a[15:0], u[7:0], 4'h0, k, 16'hc3c3, a[15:0]}, 2'b00});
    end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= wd;
    req_strb_i <= st;
    req_nonsecure_i <= ns;
    redist_total_i <= n[3:0];
    {ue, dis, sd} <= {e_ue, e_dis, e_sd};
    delay <= 2'($random(seed));
    i = 0;
    do begin
      @(negedge clk_sys_i);
      i++;
    end while (req_ready_o !== 1'b1 && i < 50);
    `CHK("req_ready", 1'b1, req_ready_o)
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    i = 0;
    do begin
      @(negedge clk_sys_i);
      i++;
    end while (rsp_valid_o !== 1'b1 && i < 50);
    `CHK("rsp_valid", 1'b1, rsp_valid_o)
  endtask

  always @(negedge clk_sys_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (rsp_q.size() == 0) begin
        `CHK("rsp_extra", 1'b0, 1'b1)
      end else begin
        re = rsp_q.pop_front();
        `CHK("rsp_rdata", re[65:2], rsp_rdata_o)
        `CHK("rsp_error", re[1], rsp_error_o)
        `CHK("bad_access", re[0], bad_access_o)
      end
    end
    if (bank_valid_o === 1'b1 && !bank_seen) begin
      if (bank_q.size() == 0) begin
        `CHK("bank_extra", 1'b0, 1'b1)
      end else begin
        be = bank_q.pop_front();
        `CHK("bank_kind", be[27:24], bank_kind_o)
        `CHK("bank_offset", be[15:0], bank_offset_o)
        `CHK("bank_wr", be[100:28], {bank_write_o, bank_wdata_o, bank_strb_o})
        if (be[27:24] inside {[4'd4:4'd9]}) begin
          `CHK("bank_unit", be[23:16], bank_unit_o)
        end
      end
    end
    bank_seen = (bank_valid_o === 1'b1);
  end

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    test_done();
  end

  initial begin
    logic [15:0] ofs;
    repeat (2) @(negedge clk_sys_i);
    `CHK("rst_out", 5'b10000, {req_ready_o, rsp_valid_o, bank_valid_o, bad_access_o, rsp_error_o})
    `CHK("rst_rdata", 64'h0, rsp_rdata_o)
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (pages[j]) begin
      acc(1'b0, {10'h0, pages[j][5:0], 16'hffe4}, 1'b0, 8);
      acc(1'b1, {10'h0, pages[j][5:0], 16'hffe0}, 1'b0, 8);
    end
    foreach (pages[j]) acc(1'b0, {10'h0, 6'd44 - 6'(4 * j), 16'hffe0}, 1'b0, 8 - j);
    for (int n = 8; n >= 0; n -= 4) begin
      for (int p = 0; p < 64; p++) begin
        ofs = 16'($random(seed));
        if (($random(seed) & 3) == 0) ofs = 16'hffd0 + 16'($unsigned($random(seed)) % 48);
        acc(1'($random(seed)), {10'($random(seed)), 6'(p), ofs}, 1'($random(seed)), n);
      end
    end
    repeat (4) @(posedge clk_sys_i);
    `CHK("queues_empty", 0, rsp_q.size() + bank_q.size())
    test_done();
  end
endmodule
